// file: src/unsigned_compare_unit.sv
// Decode and execute of the two unsigned compare instructions
`timescale 1ns/1ps
module unsigned_compare_unit #(
    parameter int DATA_W = ucmp_pkg::DATA_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction issue from the sequencer
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [DATA_W-1:0] src_a_value,
    input wire logic [DATA_W-1:0] src_b_value,
    // Overflow updates from other ALU instructions
    input wire logic ovf_write,
    input wire logic ovf_value,
    // Outcome towards branch logic
    output logic cmp_done,
    output logic branch_taken,
    output logic equal_flag,
    output logic below_flag,
    output logic [2:0] cond_code,
    output logic always_execute_bit,
    output logic [5:0] src_a_sel,
    output logic [4:0] src_b_sel,
    // Architectural side effects
    output logic overflow_flag,
    output logic dest_write
);
    // ==========================================================
    // Field extraction
    function automatic logic [DATA_W-1:0] widen_imm(input logic [31:0] w);
        widen_imm = {{(DATA_W - ucmp_pkg::IMM_W){w[ucmp_pkg::IMM_HI]}}, w[ucmp_pkg::IMM_HI:0]};
    endfunction

    function automatic logic fixed_fields_ok(input logic [31:0] w, input logic [6:0] opc);
        fixed_fields_ok = (w[ucmp_pkg::OPC_HI:ucmp_pkg::OPC_LO] == opc)
            && (w[ucmp_pkg::ZERO_HI:ucmp_pkg::ZERO_LO] == ucmp_pkg::ZERO_FIELD);
    endfunction

    // Instruction decode
    wire is_reg_cmp = fixed_fields_ok(instr, ucmp_pkg::OPC_REG_CMP)
        && (instr[ucmp_pkg::MARK_HI:ucmp_pkg::MARK_LO] == ucmp_pkg::REG_MARK);
    wire is_imm_cmp = fixed_fields_ok(instr, ucmp_pkg::OPC_IMM_CMP);
    wire compare_two_registers = instr_valid && is_reg_cmp;
    wire compare_register_immediate = instr_valid && is_imm_cmp;
    wire any_cmp = compare_two_registers || compare_register_immediate;
    wire [2:0] cond_w = instr[ucmp_pkg::COND_HI:ucmp_pkg::COND_LO];
    wire [5:0] sel_a_w = instr[ucmp_pkg::SRCA_HI:ucmp_pkg::SRCA_LO];
    wire [4:0] sel_b_w = instr[ucmp_pkg::SRCB_HI:ucmp_pkg::SRCB_LO];
    // Immediate form has no always-execute bit
    wire always_exec_w = is_reg_cmp && instr[ucmp_pkg::ALWAYS_EXEC_POS];
    wire [DATA_W-1:0] imm_w = widen_imm(instr);

    // ==========================================================
    // Operand selection into the compare core
    ucmp_link_if #(.W(DATA_W)) lnk ();
    assign lnk.opa = src_a_value;
    assign lnk.opb = is_imm_cmp ? imm_w : src_b_value;
    assign lnk.cond = cond_w;

    ucmp_core u_core (
        .lnk(lnk.core)
    );

    // ==========================================================
    // Outcome registers
    logic done_ff;
    logic taken_ff;
    logic equal_ff;
    logic below_ff;
    logic [2:0] cond_ff;
    logic always_exec_ff;
    logic [5:0] sel_a_ff;
    logic [4:0] sel_b_ff;
    logic ovf_ff;
    logic dest_ff;
    // Compare wins over an overflow write in the same cycle
    wire nxt_ovf = (ovf_write && !any_cmp) ? ovf_value : ovf_ff;

    // Capture outcome, fresh from current operands each compare
    always_ff @(posedge clk) begin
        if (rst) begin
            done_ff <= 1'b0;
            taken_ff <= 1'b0;
            equal_ff <= 1'b0;
            below_ff <= 1'b0;
            cond_ff <= 3'h0;
            always_exec_ff <= 1'b0;
            sel_a_ff <= 6'h00;
            sel_b_ff <= 5'h00;
        end else begin
            done_ff <= any_cmp;
            if (any_cmp) begin
                taken_ff <= lnk.taken;
                equal_ff <= lnk.equal;
                below_ff <= lnk.below;
                cond_ff <= cond_w;
                always_exec_ff <= always_exec_w;
                sel_a_ff <= sel_a_w;
                sel_b_ff <= is_reg_cmp ? sel_b_w : 5'h00;
            end
        end
    end

    // Overflow flag and destination write strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_ff <= ucmp_pkg::OVF_RESET;
            dest_ff <= 1'b0;
        end else begin
            ovf_ff <= nxt_ovf;
            dest_ff <= instr_valid && !any_cmp;
        end
    end

    // Output drive
    assign cmp_done = done_ff;
    assign branch_taken = taken_ff;
    assign equal_flag = equal_ff;
    assign below_flag = below_ff;
    assign cond_code = cond_ff;
    assign always_execute_bit = always_exec_ff;
    assign src_a_sel = sel_a_ff;
    assign src_b_sel = sel_b_ff;
    assign overflow_flag = ovf_ff;
    assign dest_write = dest_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Decode of both instruction forms
    reg_decode_a: assert property (instr_valid && instr[31:25] == 7'h74 && instr[24:19] == 6'h00
        && instr[9:6] == 4'hf |=> cmp_done)
        else $error("register compare not decoded");
    imm_decode_a: assert property (instr_valid && instr[31:25] == 7'h7c && instr[24:19] == 6'h00
        |=> cmp_done && !always_execute_bit)
        else $error("immediate compare not decoded");
    bad_mark_a: assert property (instr_valid && instr[31:25] == 7'h74 && instr[9:6] != 4'hf
        |=> !cmp_done)
        else $error("compare decoded with wrong marker bits");
    bad_zero_a: assert property (instr_valid && instr[24:19] != 6'h00
        |=> !cmp_done)
        else $error("compare decoded with nonzero zero field");

    // Unsigned relation of the operands
    reg_below_a: assert property (compare_two_registers |=> below_flag == ($past(src_a_value)
        < $past(src_b_value)) && equal_flag == ($past(src_a_value) == $past(src_b_value)))
        else $error("register compare relation wrong");
    imm_widen_a: assert property (compare_register_immediate |=> below_flag == ($past(src_a_value)
        < {{22{$past(instr[9])}}, $past(instr[9:0])}))
        else $error("immediate compare relation wrong");
    imm_equal_a: assert property (compare_register_immediate |=> equal_flag == ($past(src_a_value)
        == {{22{$past(instr[9])}}, $past(instr[9:0])}))
        else $error("immediate compare equality wrong");

    // Condition set of the compares
    taken_equal_a: assert property (any_cmp && cond_w == 3'h0
        |=> branch_taken == equal_flag)
        else $error("equal condition not evaluated");
    taken_not_equal_a: assert property (any_cmp && cond_w == 3'h1
        |=> branch_taken == !equal_flag)
        else $error("not equal condition not evaluated");
    taken_below_a: assert property (any_cmp && cond_w == 3'h2
        |=> branch_taken == below_flag)
        else $error("below condition not evaluated");
    taken_above_equal_a: assert property (any_cmp && cond_w == 3'h3
        |=> branch_taken == !below_flag)
        else $error("above or equal condition not evaluated");
    taken_above_a: assert property (any_cmp && cond_w == 3'h4
        |=> branch_taken == (!below_flag && !equal_flag))
        else $error("above condition not evaluated");
    taken_below_equal_a: assert property (any_cmp && cond_w == 3'h5
        |=> branch_taken == (below_flag || equal_flag))
        else $error("below or equal condition not evaluated");
    taken_fixed_a: assert property (any_cmp && cond_w[2:1] == 2'h3
        |=> branch_taken == !$past(cond_w[0]))
        else $error("always or never condition not evaluated");

    // Outcome fields and their holding
    fields_capture_a: assert property (any_cmp
        |=> cond_code == $past(instr[18:16]) && src_a_sel == $past(instr[15:10]))
        else $error("condition or source field not captured");
    sel_b_imm_a: assert property (compare_register_immediate
        |=> src_b_sel == 5'h00)
        else $error("second source kept after immediate compare");
    exec_bit_a: assert property (compare_two_registers
        |=> always_execute_bit == $past(instr[5]) && src_b_sel == $past(instr[4:0]))
        else $error("register compare fields not captured");
    outcome_hold_a: assert property (!any_cmp
        |=> $stable(branch_taken) && $stable(equal_flag) && $stable(below_flag) && $stable(cond_code))
        else $error("outcome changed without compare");
    done_pulse_a: assert property (!any_cmp
        |=> !cmp_done)
        else $error("outcome without compare");

    // Side effects: overflow keeps its value across compares
    // and a compare never writes a destination
    ovf_hold_a: assert property (any_cmp
        |=> $stable(overflow_flag))
        else $error("overflow changed by compare");
    ovf_idle_a: assert property (!ovf_write
        |=> $stable(overflow_flag))
        else $error("overflow changed without write");
    ovf_take_a: assert property (ovf_write && !any_cmp
        |=> overflow_flag == $past(ovf_value))
        else $error("overflow write not taken");
    no_write_a: assert property (any_cmp
        |=> !dest_write)
        else $error("compare wrote a destination");
    dest_pulse_a: assert property (instr_valid && !any_cmp
        |=> dest_write)
        else $error("other instruction lost its destination write");

    // Main scenarios
    reg_cmp_c: cover property (compare_two_registers ##1 branch_taken);
    imm_neg_c: cover property (compare_register_immediate && instr[9]);
    back_to_back_c: cover property (compare_two_registers ##1 compare_register_immediate);
    ovf_blocked_c: cover property (any_cmp && ovf_write);
    ovf_clear_c: cover property (ovf_write && !ovf_value && !any_cmp);
endmodule // unsigned_compare_unit

// file: src/ucmp_pkg.sv
// Constants for the unsigned compare unit
// Summary of operation
// - Register compare: bits 31:25 = 1110100, bits 24:19 zero, bits 9:6 = 1111.
// - Register compare weighs first source against second source as unsigned numbers.
// - Compare outcome drives branch condition evaluation to redirect program flow.
// - Plain register compare uses only current operands, no earlier compare result.
// - Either compare leaves the overflow flag exactly as it was.
// - Immediate compare: bits 31:25 = 1111100, bits 24:19 zero, bits 9:0 immediate.
// - Ten-bit immediate widened by copying its bit 9 into bits 31:10.
// - Immediate compare treats register and widened immediate as unsigned numbers.
// - Compares evaluate the condition field with the compare-specific condition set.
package ucmp_pkg;
    // ==========================================================
    // Instruction fields
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 25;
    localparam int ZERO_HI = 24;
    localparam int ZERO_LO = 19;
    localparam int COND_HI = 18;
    localparam int COND_LO = 16;
    localparam int SRCA_HI = 15;
    localparam int SRCA_LO = 10;
    localparam int MARK_HI = 9;
    localparam int MARK_LO = 6;
    localparam int ALWAYS_EXEC_POS = 5;
    localparam int SRCB_HI = 4;
    localparam int SRCB_LO = 0;
    localparam int IMM_HI = 9;
    localparam int IMM_W = 10;
    localparam int DATA_W = 32;
    localparam logic [6:0] OPC_REG_CMP = 7'h74;
    localparam logic [6:0] OPC_IMM_CMP = 7'h7c;
    localparam logic [5:0] ZERO_FIELD = 6'h00;
    localparam logic [3:0] REG_MARK = 4'hf;
    // ==========================================================
    // Compare-specific condition codes
    localparam logic [2:0] CC_EQUAL = 3'h0;
    localparam logic [2:0] CC_NOT_EQUAL = 3'h1;
    localparam logic [2:0] CC_BELOW = 3'h2;
    localparam logic [2:0] CC_ABOVE_EQUAL = 3'h3;
    localparam logic [2:0] CC_ABOVE = 3'h4;
    localparam logic [2:0] CC_BELOW_EQUAL = 3'h5;
    localparam logic [2:0] CC_ALWAYS = 3'h6;
    localparam logic [2:0] CC_NEVER = 3'h7;
    // ==========================================================
    // Reset values
    localparam logic OVF_RESET = 1'b0;
endpackage

// file: src/ucmp_link_if.sv
// Operand and outcome carrier between decode and compare core
`timescale 1ns/1ps
interface ucmp_link_if #(parameter int W = 32);
    logic [W-1:0] opa;
    logic [W-1:0] opb;
    logic [2:0] cond;
    logic taken;
    logic equal;
    logic below;
    modport core (input opa, input opb, input cond, output taken, output equal, output below);
    modport user (output opa, output opb, output cond, input taken, input equal, input below);
endinterface

// file: src/ucmp_core.sv
// Unsigned magnitude compare and condition evaluation
`timescale 1ns/1ps
module ucmp_core (
    ucmp_link_if.core lnk
);
    // ==========================================================
    // Unsigned relation of the two operands
    wire eq_w = (lnk.opa == lnk.opb);
    wire lt_w = (lnk.opa < lnk.opb);
    assign lnk.equal = eq_w;
    assign lnk.below = lt_w;

    // Compare-specific condition set
    always_comb begin
        case (lnk.cond)
            ucmp_pkg::CC_EQUAL: lnk.taken = eq_w;
            ucmp_pkg::CC_NOT_EQUAL: lnk.taken = !eq_w;
            ucmp_pkg::CC_BELOW: lnk.taken = lt_w;
            ucmp_pkg::CC_ABOVE_EQUAL: lnk.taken = !lt_w;
            ucmp_pkg::CC_ABOVE: lnk.taken = !lt_w && !eq_w;
            ucmp_pkg::CC_BELOW_EQUAL: lnk.taken = lt_w || eq_w;
            ucmp_pkg::CC_ALWAYS: lnk.taken = 1'b1;
            default: lnk.taken = 1'b0;
        endcase
    end
endmodule // ucmp_core

// file: dv/ucmp_seq_model.sv
// Sequencer model that issues instructions to the compare unit
`timescale 1ns/1ps
module ucmp_seq_model (
    // Clock
    input wire logic clk,
    // Issue towards the unit
    output logic instr_valid,
    output logic [31:0] instr,
    output logic [31:0] src_a_value,
    output logic [31:0] src_b_value
);
    // ==========================================================
    // Idle state at time zero
    initial begin
        instr_valid = 1'b0;
        instr = 32'h0;
        src_a_value = 32'h0;
        src_b_value = 32'h0;
    end
    // Put one instruction on the port at the next edge
    task automatic drive(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= w;
        src_a_value <= a;
        src_b_value <= b;
    endtask
    // Drop valid at the next edge; instruction and operands are inverted, not held
    task automatic idle;
        @(posedge clk);
        instr_valid <= 1'b0;
        instr <= ~instr;
        src_a_value <= ~src_a_value;
        src_b_value <= ~src_b_value;
    endtask
    // One instruction for one cycle
    task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
        drive(w, a, b);
        idle();
    endtask
endmodule // ucmp_seq_model

// file: dv/unsigned_compare_unit_tb_top.sv
// Self-checking bench for the unsigned compare unit
`timescale 1ns/1ps
module unsigned_compare_unit_tb_top;
    logic clk, rst, ovf_write, ovf_value, instr_valid;
    logic [31:0] instr, src_a_value, src_b_value;
    logic cmp_done, branch_taken, equal_flag, below_flag, always_execute_bit, overflow_flag, dest_write;
    logic [2:0] cond_code;
    logic [5:0] src_a_sel;
    logic [4:0] src_b_sel;
    int n_errors = 0;
    int samples_checked = 0;
    logic [31:0] av [3] = '{32'h5, 32'h9, 32'hffff_fff0};
    logic [31:0] bv [3] = '{32'h9, 32'h9, 32'h1};
    // ==========================================================
    // Clock, reset and instances
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ucmp_seq_model u_seq (.clk(clk), .instr_valid(instr_valid), .instr(instr),
        .src_a_value(src_a_value), .src_b_value(src_b_value));
    unsigned_compare_unit u_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .src_a_value(src_a_value), .src_b_value(src_b_value), .ovf_write(ovf_write),
        .ovf_value(ovf_value), .cmp_done(cmp_done), .branch_taken(branch_taken),
        .equal_flag(equal_flag), .below_flag(below_flag), .cond_code(cond_code),
        .always_execute_bit(always_execute_bit), .src_a_sel(src_a_sel), .src_b_sel(src_b_sel),
        .overflow_flag(overflow_flag), .dest_write(dest_write));
    // ==========================================================
    // Compare tasks and expected outcome
    task automatic chk_flag(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %b", $time, what, got);
        end
    endtask
    task automatic chk_field(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h", $time, what, got);
        end
    endtask
    function automatic logic outcome(input logic [31:0] a, input logic [31:0] b, input int c);
        logic [5:0] t;
        t = {a == b, a != b, a < b, a >= b, a > b, a <= b};
        return (c < 6) ? t[5 - c] : (c == 6);
    endfunction
    // Judge every outcome field of one compare
    task automatic judge(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b, input logic imm);
        logic [31:0] opb;
        opb = imm ? {{22{w[9]}}, w[9:0]} : b;
        chk_flag(cmp_done, 1'b1, "done");
        chk_flag(branch_taken, outcome(a, opb, int'(w[18:16])), "taken");
        chk_flag(equal_flag, a == opb, "equal");
        chk_flag(below_flag, a < opb, "below");
        chk_field(8'(cond_code), 8'(w[18:16]), "cond");
        chk_field(8'(src_a_sel), 8'(w[15:10]), "sel a");
        chk_field(8'(src_b_sel), imm ? 8'h00 : 8'(w[4:0]), "sel b");
        chk_flag(always_execute_bit, imm ? 1'b0 : w[5], "always exec");
        chk_flag(dest_write, 1'b0, "dest");
    endtask
    // One compare and its judged results
    task automatic run_cmp(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b, input logic imm);
        u_seq.issue(w, a, b);
        #1 judge(w, a, b, imm);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reg_all_conds;
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 3; k++) begin
                run_cmp({7'h74, 6'h00, 3'(c), 6'(c + 40), 4'hf, 1'(k), 5'(k + 3)}, av[k], bv[k], 1'b0);
            end
        end
    endtask
    task automatic t_imm_all_conds;
        for (int c = 0; c < 8; c++) begin
            run_cmp({7'h7c, 6'h00, 3'(c), 6'h11, 10'h200}, 32'h100, 32'h0, 1'b1);
            run_cmp({7'h7c, 6'h00, 3'(c), 6'h12, 10'h200}, 32'hffff_fe00, 32'h0, 1'b1);
            run_cmp({7'h7c, 6'h00, 3'(c), 6'h13, 10'h1ff}, 32'h200, 32'hffff_ffff, 1'b1);
        end
    endtask
    task automatic t_refused;
        u_seq.issue({7'h74, 6'h00, 3'h0, 6'h01, 4'he, 1'b0, 5'h02}, 32'h1, 32'h1);
        #1 chk_flag(cmp_done, 1'b0, "bad mark");
        chk_flag(dest_write, 1'b1, "not a compare");
        u_seq.issue({7'h74, 6'h01, 3'h0, 6'h01, 4'hf, 1'b0, 5'h02}, 32'h1, 32'h1);
        #1 chk_flag(cmp_done, 1'b0, "bad zero");
        u_seq.issue({7'h7c, 6'h20, 3'h0, 6'h01, 10'h001}, 32'h1, 32'h1);
        #1 chk_flag(cmp_done, 1'b0, "bad imm zero");
    endtask
    // Two compares on consecutive edges with flipped outcomes, then the done pulse falls
    task automatic t_back_to_back;
        logic [31:0] w0, w1;
        w0 = {7'h74, 6'h00, 3'h2, 6'h21, 4'hf, 1'b1, 5'h04};
        w1 = {7'h7c, 6'h00, 3'h2, 6'h22, 10'h005};
        u_seq.drive(w0, 32'h5, 32'h9);
        u_seq.drive(w1, 32'h5, 32'h9);
        #1 judge(w0, 32'h5, 32'h9, 1'b0);
        u_seq.idle();
        #1 judge(w1, 32'h5, 32'h9, 1'b1);
        @(posedge clk);
        #1 chk_flag(cmp_done, 1'b0, "done pulse");
        chk_field(8'(cond_code), 8'h02, "cond held");
        chk_flag(equal_flag, 1'b1, "equal held");
    endtask
    // One overflow write from another instruction
    task automatic write_ovf(input logic v);
        @(posedge clk);
        ovf_write <= 1'b1;
        ovf_value <= v;
        @(posedge clk);
        ovf_write <= 1'b0;
    endtask
    task automatic t_overflow;
        write_ovf(1'b1);
        #1 chk_flag(overflow_flag, 1'b1, "ovf set");
        fork
            u_seq.issue({7'h74, 6'h00, 3'h2, 6'h05, 4'hf, 1'b1, 5'h06}, 32'h1, 32'h2);
            write_ovf(1'b0);
        join
        #1 chk_flag(overflow_flag, 1'b1, "ovf kept");
        run_cmp({7'h7c, 6'h00, 3'h1, 6'h07, 10'h003}, 32'h3, 32'h0, 1'b1);
        chk_flag(overflow_flag, 1'b1, "ovf kept imm");
        write_ovf(1'b0);
        #1 chk_flag(overflow_flag, 1'b0, "ovf cleared");
    endtask
    // ==========================================================
    // Closing, watchdog and main sequence
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        ovf_write = 1'b0;
        ovf_value = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk_flag(cmp_done | branch_taken | overflow_flag | dest_write, 1'b0, "reset");
        t_reg_all_conds();
        t_imm_all_conds();
        t_back_to_back();
        t_refused();
        t_overflow();
        final_report();
    end
endmodule // unsigned_compare_unit_tb_top
